// file: core/aiwf_skid.sv
// two-entry buffer with valid/ready on both sides
`timescale 1ns/1ps
module aiwf_skid #(
    parameter int W = 16
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_resetn,
    // fill side
    input wire logic i_valid,
    input wire logic [W-1:0] i_data,
    output logic o_ready,
    // drain side
    output logic o_valid,
    output logic [W-1:0] o_data,
    input wire logic i_ready
);
    logic [W-1:0] mem_q [2];
    logic [W-1:0] mem_d [2];
    logic rd_q, rd_d, wr_q, wr_d;
    logic [1:0] cnt_q, cnt_d;
    logic push, pop;

    always_comb begin
        push = i_valid && (cnt_q != 2'h2);
        pop = (cnt_q != 2'h0) && i_ready;
        mem_d = mem_q;
        wr_d = wr_q;
        rd_d = rd_q;
        if (push) begin
            mem_d[wr_q] = i_data;
            wr_d = ~wr_q;
        end
        if (pop) begin
            rd_d = ~rd_q;
        end
        cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            mem_q <= mem_d;
            rd_q <= rd_d;
            wr_q <= wr_d;
            cnt_q <= cnt_d;
        end
    end

    assign o_ready = (cnt_q != 2'h2);
    assign o_valid = (cnt_q != 2'h0);
    assign o_data = mem_q[rd_q];
endmodule : aiwf_skid

// file: core/aiwf_top.sv
// output word formatter of an eight-channel analog input module
`timescale 1ns/1ps
module aiwf_top (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_resetn,
    // converter side, same clock domain
    input wire logic i_conv_valid,
    input wire logic [2:0] i_conv_chan,
    input wire logic [11:0] i_conv_mag,
    input wire logic i_conv_neg,
    input wire logic i_bipolar,
    // module pins
    input wire logic i_field_power_ok,
    input wire logic [2:0] i_chan_jumpers,
    // host scan
    input wire logic i_scan_strobe,
    // host input word
    output logic [15:0] o_input_word,
    output logic o_chan_code_bit0,
    output logic o_chan_code_bit1,
    output logic o_chan_code_bit2,
    output logic o_word_valid
);
    // latest conversion per channel, written whenever the converter finishes
    logic [11:0] mag_q [aiwf_pkg::NUM_CHAN];
    logic [11:0] mag_d [aiwf_pkg::NUM_CHAN];
    logic neg_q [aiwf_pkg::NUM_CHAN];
    logic neg_d [aiwf_pkg::NUM_CHAN];
    // pin synchronisers
    logic pwr_s1_q, pwr_s2_q;
    logic [2:0] jmp_s1_q, jmp_s2_q;
    logic scan_s1_q, scan_s2_q, scan_s3_q;
    // scan sequencer
    logic [2:0] chan_q, chan_d;
    logic [15:0] word_q, word_d;
    logic buf_valid, buf_ready;
    logic [15:0] buf_data;
    logic out_valid;
    logic [15:0] out_data;
    logic scan_evt;
    logic [2:0] last_chan;
    logic [11:0] sel_mag;
    logic sel_neg;
    logic msb;

    always_comb begin
        mag_d = mag_q;
        neg_d = neg_q;
        if (i_conv_valid) begin
            // counts stored as given, weight per count set by the range
            mag_d[i_conv_chan] = i_conv_mag;
            // unipolar never carries a sign
            neg_d[i_conv_chan] = i_bipolar && i_conv_neg;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            for (int k = 0; k < aiwf_pkg::NUM_CHAN; k++) begin
                mag_q[k] <= 12'h000;
                neg_q[k] <= 1'b0;
            end
        end else begin
            mag_q <= mag_d;
            neg_q <= neg_d;
        end
    end

    // pins cross in through two flops before any use
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            pwr_s1_q <= 1'b0;
            pwr_s2_q <= 1'b0;
            jmp_s1_q <= 3'h0;
            jmp_s2_q <= 3'h0;
            scan_s1_q <= 1'b0;
            scan_s2_q <= 1'b0;
            scan_s3_q <= 1'b0;
        end else begin
            pwr_s1_q <= i_field_power_ok;
            pwr_s2_q <= pwr_s1_q;
            jmp_s1_q <= i_chan_jumpers;
            jmp_s2_q <= jmp_s1_q;
            scan_s1_q <= i_scan_strobe;
            scan_s2_q <= scan_s1_q;
            scan_s3_q <= scan_s2_q;
        end
    end

    always_comb begin
        scan_evt = scan_s2_q && !scan_s3_q;
        last_chan = jmp_s2_q;
        sel_mag = mag_q[chan_q];
        sel_neg = neg_q[chan_q];
        // no supply forces zero data with msb set, no sign then
        if (!pwr_s2_q) begin
            sel_mag = 12'h000;
            msb = 1'b1;
        end else begin
            // a zero reading cannot carry a sign, else it would read as a fault
            msb = sel_neg && (sel_mag != 12'h000);
        end
        chan_d = chan_q;
        word_d = word_q;
        if (scan_evt && buf_ready) begin
            // one word built at once so fields never mix channels
            word_d = {msb, chan_q, sel_mag};
            if (chan_q >= last_chan) begin
                chan_d = aiwf_pkg::CHAN_RST;
            end else begin
                chan_d = chan_q + 3'h1;
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            chan_q <= aiwf_pkg::CHAN_RST;
            word_q <= aiwf_pkg::WORD_RST;
        end else begin
            chan_q <= chan_d;
            word_q <= word_d;
        end
    end

    logic push_q, push_d;
    always_comb begin
        push_d = scan_evt && buf_ready;
    end
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            push_q <= 1'b0;
        end else begin
            push_q <= push_d;
        end
    end
    assign buf_valid = push_q;
    assign buf_data = word_q;

    aiwf_skid #(
        .W(aiwf_pkg::WORD_W)
    ) u_skid (
        .i_mclk(i_mclk),
        .i_resetn(i_resetn),
        .i_valid(buf_valid),
        .i_data(buf_data),
        .o_ready(buf_ready),
        .o_valid(out_valid),
        .o_data(out_data),
        .i_ready(1'b1)
    );

    // output register holds the word steady for the whole scan
    logic [15:0] oword_q, oword_d;
    logic ovalid_q, ovalid_d;
    always_comb begin
        oword_d = oword_q;
        ovalid_d = ovalid_q;
        if (out_valid) begin
            oword_d = out_data;
            ovalid_d = 1'b1;
        end
    end
    always_ff @(posedge i_mclk) begin
        if (!i_resetn) begin
            oword_q <= aiwf_pkg::WORD_RST;
            ovalid_q <= 1'b0;
        end else begin
            oword_q <= oword_d;
            ovalid_q <= ovalid_d;
        end
    end
    assign o_input_word = oword_q;
    assign o_chan_code_bit0 = oword_q[aiwf_pkg::CODE_LSB];
    assign o_chan_code_bit1 = oword_q[aiwf_pkg::CODE_LSB + 1];
    assign o_chan_code_bit2 = oword_q[aiwf_pkg::CODE_LSB + 2];
    assign o_word_valid = ovalid_q;
endmodule : aiwf_top

// file: dv/aiwf_asserts.sv
// assertions on the word formatter ports
`timescale 1ns/1ps
module aiwf_asserts (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_resetn,
    // pins
    input wire logic i_field_power_ok,
    input wire logic i_scan_strobe,
    // host word
    input wire logic [15:0] o_input_word,
    input wire logic o_chan_code_bit0,
    input wire logic o_chan_code_bit1,
    input wire logic o_chan_code_bit2,
    input wire logic o_word_valid
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);
    a_code_copy: assert property ({o_chan_code_bit2, o_chan_code_bit1, o_chan_code_bit0}
        == o_input_word[14:12]) else $error("code pins");
    a_word_hold: assert property ($changed(o_input_word) |-> $past(i_scan_strobe, 3))
        else $error("word moved without scan");
    a_code_step: assert property ($changed(o_input_word[14:12]) && $past(o_word_valid) |->
        o_input_word[14:12] == $past(o_input_word[14:12]) + 3'h1 || o_input_word[14:12] == 3'h0)
        else $error("channel step");
    a_msb_zero: assert property ($changed(o_input_word) && $past(i_field_power_ok, 3)
        && $past(i_field_power_ok, 8) |-> !(o_input_word[15] && o_input_word[11:0] == 12'h000))
        else $error("supply flag with supply present");
    a_pwr_flag: assert property ((!i_field_power_ok)[*8] ##0 $rose(i_scan_strobe)
        ##1 (!i_field_power_ok)[*6] |-> ##1 (o_input_word[15] && o_input_word[11:0] == 12'h000))
        else $error("supply flag missing");
    a_valid_after: assert property ($rose(i_scan_strobe) |-> ##7 o_word_valid)
        else $error("no word after scan");
    a_valid_holds: assert property (o_word_valid |=> o_word_valid)
        else $error("valid dropped");
    a_reset_clear: assert property ($rose(i_resetn) |-> o_input_word == aiwf_pkg::WORD_RST
        && !o_word_valid) else $error("outputs not cleared");
endmodule : aiwf_asserts
bind aiwf_top aiwf_asserts u_chk (.i_mclk, .i_resetn, .i_field_power_ok, .i_scan_strobe,
    .o_input_word, .o_chan_code_bit0, .o_chan_code_bit1, .o_chan_code_bit2, .o_word_valid);

// file: dv/aiwf_host_model.sv
// host model: one channel read per scan
`timescale 1ns/1ps
module aiwf_host_model (
    // clock
    input wire logic i_mclk,
    // scan control
    input wire logic i_go,
    input wire logic [15:0] i_input_word,
    output logic o_scan_strobe = 1'b0,
    output logic [15:0] o_word
);
    int cnt = 99;
    always @(posedge i_mclk) begin
        cnt <= i_go ? 0 : (cnt < 99 ? cnt + 1 : cnt);
        o_scan_strobe <= i_go || cnt < 3;
        // read late so sync and buffer delay have passed
        if (cnt == 10) o_word <= i_input_word;
    end
endmodule : aiwf_host_model

// file: dv/aiwf_tb_top.sv
// self-checking bench for the word formatter
`timescale 1ns/1ps
module aiwf_tb_top;
    typedef struct packed {logic bip; logic neg; logic [11:0] mag; logic [15:0] wrd;} aiwf_row_t;
    logic i_mclk = 1'b0, i_resetn = 1'b0, i_conv_valid = 1'b0, i_conv_neg = 1'b0;
    logic i_bipolar = 1'b0, i_field_power_ok = 1'b1, go = 1'b0;
    logic [2:0] i_conv_chan = 3'h0, i_chan_jumpers = 3'h7;
    logic [11:0] i_conv_mag = 12'h000;
    logic i_scan_strobe, o_chan_code_bit0, o_chan_code_bit1, o_chan_code_bit2, o_word_valid;
    logic [15:0] o_input_word, seen;
    int bad_count = 0, checks_done = 0;
    aiwf_row_t rows [8] = '{
        '{1'b0, 1'b0, 12'h000, 16'h0000},
        '{1'b0, 1'b0, 12'hFFF, 16'h1FFF},
        '{1'b1, 1'b1, 12'h001, 16'hA001},
        '{1'b1, 1'b1, 12'hFFF, 16'hBFFF},
        '{1'b1, 1'b0, 12'h800, 16'h4800},
        '{1'b0, 1'b1, 12'h555, 16'h5555},
        '{1'b1, 1'b1, 12'h000, 16'h6000},
        '{1'b0, 1'b0, 12'hAAA, 16'h7AAA}};
    aiwf_top u_dut (.i_mclk, .i_resetn, .i_conv_valid, .i_conv_chan, .i_conv_mag, .i_conv_neg,
        .i_bipolar, .i_field_power_ok, .i_chan_jumpers, .i_scan_strobe, .o_input_word,
        .o_chan_code_bit0, .o_chan_code_bit1, .o_chan_code_bit2, .o_word_valid);
    aiwf_host_model u_host (.i_mclk, .i_go(go), .i_input_word(o_input_word),
        .o_scan_strobe(i_scan_strobe), .o_word(seen));
    always #2.5 i_mclk = ~i_mclk;
    task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic scan();
        go <= 1'b1;
        @(posedge i_mclk);
        go <= 1'b0;
        repeat (13) @(posedge i_mclk);
    endtask : scan
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (10) @(posedge i_mclk);
        check("reset word", o_input_word, 16'h0000);
        check("reset valid", {15'h0, o_word_valid}, 16'h0000);
        i_resetn <= 1'b1;
        @(posedge i_mclk);
        $display("reset test done");
        // one row per channel, scans walk channels in order
        foreach (rows[i]) begin
            i_bipolar <= rows[i].bip;
            i_conv_valid <= 1'b1;
            i_conv_chan <= 3'(i);
            i_conv_mag <= rows[i].mag;
            i_conv_neg <= rows[i].neg;
            @(posedge i_mclk);
            i_conv_valid <= 1'b0;
            scan();
            check("word", seen, rows[i].wrd);
            check("valid", {15'h0, o_word_valid}, 16'h0001);
            check("code", {13'h0, o_chan_code_bit2, o_chan_code_bit1, o_chan_code_bit0},
                {13'h0, rows[i].wrd[14:12]});
        end
        $display("table test done");
        i_field_power_ok <= 1'b0;
        repeat (10) @(posedge i_mclk);
        scan();
        check("no supply", seen, 16'h8000);
        i_field_power_ok <= 1'b1;
        i_chan_jumpers <= 3'h1;
        repeat (4) @(posedge i_mclk);
        scan();
        check("two chan a", seen, 16'h1FFF);
        scan();
        check("two chan b", seen, 16'h0000);
        $display("supply and wrap test done");
        print_verdict();
    end
    initial begin
        repeat (1000) @(posedge i_mclk);
        bad_count++;
        $display("watchdog expired");
        print_verdict();
    end
endmodule : aiwf_tb_top

// file: pkg/aiwf_pkg.sv
// shared constants for the analog input word formatter
package aiwf_pkg;
    localparam int WORD_W = 16;
    localparam int DATA_W = 12;
    localparam int CHAN_W = 3;
    localparam int NUM_CHAN = 8;
    localparam int DATA_LSB = 0;
    localparam int CODE_LSB = 12;
    localparam int MSB_POS = 15;
    localparam logic [11:0] FULL_SCALE = 12'hFFF;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [2:0] CHAN_RST = 3'h0;
    localparam int UNI_DIVISOR = 4095;
    localparam int BIP_DIVISOR = 8191;
    localparam int SCAN_GAP_NS = 10;
    localparam int SCAN_GAP_CYC = (SCAN_GAP_NS + 4) / 5;
endpackage : aiwf_pkg
